// File: design/gda_pkg.sv
// constants for the gauge data acquisition block
package gda_pkg;
   localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
   localparam int unsigned TICK_PERIOD_S    = 1;
   localparam int unsigned TICK_CYCLES      = CLK_FREQ_HZ * TICK_PERIOD_S;
   localparam int unsigned HIST_DEPTH       = 4;
   localparam int unsigned ADC_W            = 16;
   localparam int unsigned ACC_W            = 32;
   localparam int unsigned CAP_W            = 32;
   localparam logic [31:0] CAP_RESET        = 32'h0000_0000;
   localparam logic        TEMP_SRC_EXT     = 1'b0;
   localparam logic        TEMP_SRC_INT     = 1'b1;
endpackage

// File: design/gda_acquisition.sv
// gauge data acquisition: voltage, charge, current and temperature refresh
`timescale 1ns/1ps
`default_nettype none
module gda_acquisition
   import gda_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
   input  wire logic                    clk_i,                  // 250 MHz clock
   input  wire logic                    rst_i,                  // async reset, high
   input  wire logic                    normal_mode_i,          // normal mode active
   input  wire logic [ADC_W-1:0]        cell_sense_input_i,     // cell voltage sample
   input  wire logic signed [ADC_W-1:0] sense_pos_input_i,      // sense resistor plus side
   input  wire logic signed [ADC_W-1:0] sense_neg_input_i,      // sense resistor minus side
   input  wire logic [ADC_W-1:0]        thermistor_input_i,     // external thermistor sample
   input  wire logic [ADC_W-1:0]        int_temp_i,             // on-chip sensor sample
   input  wire logic                    temp_source_select_i,   // 0 external, 1 internal
   input  wire logic                    temp_query_i,           // host temperature query
   output logic [ADC_W-1:0]             voltage_o,              // reported cell voltage
   output logic signed [CAP_W-1:0]      remaining_charge_o,     // remaining charge count
   output logic signed [ACC_W-1:0]      current_o,              // reported current
   output logic [ADC_W-1:0]             temperature_o,          // reported temperature
   output logic [ADC_W-1:0]             temp_answer_o,          // query answer data
   output logic                         temp_answer_valid_o,    // query answer strobe
   output logic                         charging_o,             // charge activity
   output logic                         discharging_o,          // discharge activity
   output logic                         tick_o                  // one-second tick pulse
);

   typedef struct packed {
      logic [31:0]                      tick_cnt;
      logic                             tick;
      logic signed [ACC_W-1:0]          acc;
      // packed so the whole state stays one registered word
      logic [HIST_DEPTH-1:0][ACC_W-1:0] hist;
      logic [ADC_W-1:0]                 volt;
      logic signed [CAP_W-1:0]          cap;
      logic signed [ACC_W-1:0]          cur;
      logic [ADC_W-1:0]                 temp;
      logic [ADC_W-1:0]                 ans;
      logic                             ans_v;
      logic                             chg;
      logic                             dsg;
   } gda_state_s;

   gda_state_s state_reg;
   gda_state_s state_next;

   logic signed [ADC_W:0]   vsr_diff;
   logic signed [ACC_W-1:0] vsr_ext;
   logic signed [ACC_W+1:0] hist_sum;
   logic                    tick_now;

   // history average approximates current over the last four seconds
   function automatic logic signed [ACC_W+1:0] hist_total(input gda_state_s s);
      logic signed [ACC_W+1:0] t;
      t = '0;
      for (int i = 0; i < HIST_DEPTH; i++)
         t = t + (ACC_W+2)'($signed(s.hist[i]));
      return t;
   endfunction

   always_comb
   begin
      state_next = state_reg;
      vsr_diff   = (ADC_W+1)'(sense_pos_input_i) - (ADC_W+1)'(sense_neg_input_i);
      vsr_ext    = ACC_W'(vsr_diff);
      tick_now   = (state_reg.tick_cnt == 32'(TICK_CYC - 1));
      hist_sum   = hist_total(state_reg);
      state_next.tick     = 1'b0;
      state_next.tick_cnt = state_reg.tick_cnt + 32'h1;
      if (tick_now)
      begin
         state_next.tick_cnt = 32'h0;
         state_next.tick     = normal_mode_i;
      end
      state_next.chg = (vsr_diff > 0);
      state_next.dsg = (vsr_diff < 0);
      state_next.acc = state_reg.acc + vsr_ext;
      if (state_reg.tick)
      begin
         state_next.volt = cell_sense_input_i;
         state_next.cap  = state_reg.cap + CAP_W'(state_reg.acc);
         state_next.acc  = vsr_ext;
         state_next.hist[0] = state_reg.acc;
         for (int i = 1; i < HIST_DEPTH; i++)
            state_next.hist[i] = state_reg.hist[i-1];
         state_next.cur = ACC_W'(hist_sum >>> 2);
         state_next.temp = (temp_source_select_i == TEMP_SRC_INT) ?
                           int_temp_i : thermistor_input_i;
      end
      state_next.ans_v = temp_query_i;
      if (temp_query_i)
         state_next.ans = state_reg.temp;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign voltage_o           = state_reg.volt;
   assign remaining_charge_o  = state_reg.cap;
   assign current_o           = state_reg.cur;
   assign temperature_o       = state_reg.temp;
   assign temp_answer_o       = state_reg.ans;
   assign temp_answer_valid_o = state_reg.ans_v;
   assign charging_o          = state_reg.chg;
   assign discharging_o       = state_reg.dsg;
   assign tick_o              = state_reg.tick;

   property p_tick_period;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |-> state_reg.tick_cnt == 32'h0;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick off period");

   property p_voltage;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> voltage_o == $past(cell_sense_input_i);
   endproperty
   a_voltage: assert property (p_voltage) else $error("voltage not sampled");

   property p_volt_hold;
      @(posedge clk_i) disable iff (rst_i)
      !tick_o |=> $stable(voltage_o);
   endproperty
   a_volt_hold: assert property (p_volt_hold) else $error("voltage changed early");

   property p_charge;
      @(posedge clk_i) disable iff (rst_i)
      (sense_pos_input_i > sense_neg_input_i) |=> charging_o && !discharging_o;
   endproperty
   a_charge: assert property (p_charge) else $error("charge not flagged");

   property p_discharge;
      @(posedge clk_i) disable iff (rst_i)
      (sense_pos_input_i < sense_neg_input_i) |=> discharging_o && !charging_o;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge not flagged");

   property p_cap;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> remaining_charge_o == $past(remaining_charge_o) + CAP_W'($past(state_reg.acc));
   endproperty
   a_cap: assert property (p_cap) else $error("charge not applied");

   property p_hist;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> state_reg.hist[1] == $past(state_reg.hist[0]) &&
                 state_reg.hist[0] == $past(state_reg.acc) &&
                 state_reg.hist[3] == $past(state_reg.hist[2]);
   endproperty
   a_hist: assert property (p_hist) else $error("history not shifted");

   property p_cur_hold;
      @(posedge clk_i) disable iff (rst_i)
      !tick_o |=> $stable(current_o);
   endproperty
   a_cur_hold: assert property (p_cur_hold) else $error("current changed early");

   property p_temp;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> temperature_o == ($past(temp_source_select_i) ?
                 $past(int_temp_i) : $past(thermistor_input_i));
   endproperty
   a_temp: assert property (p_temp) else $error("wrong temperature source");

   property p_query;
      @(posedge clk_i) disable iff (rst_i)
      temp_query_i |=> temp_answer_valid_o && temp_answer_o == $past(temperature_o);
   endproperty
   a_query: assert property (p_query) else $error("query answer wrong");

   property p_temp_hold;
      @(posedge clk_i) disable iff (rst_i)
      !tick_o |=> $stable(temperature_o);
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("temperature changed early");

   // independent four-entry sum for the current check
   logic signed [ACC_W+1:0] hist_chk;
   assign hist_chk = (ACC_W+2)'($signed(state_reg.hist[0]))
                   + (ACC_W+2)'($signed(state_reg.hist[1]))
                   + (ACC_W+2)'($signed(state_reg.hist[2]))
                   + (ACC_W+2)'($signed(state_reg.hist[3]));

   property p_cur;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> current_o == ACC_W'($past(hist_chk) >>> 2);
   endproperty
   a_cur: assert property (p_cur) else $error("current not from history");

   // outside normal mode the counter runs on but voltage, charge, current, history and temperature do not refresh
   property p_no_tick;
      @(posedge clk_i) disable iff (rst_i)
      !normal_mode_i |=> !tick_o;
   endproperty
   a_no_tick: assert property (p_no_tick) else $error("tick outside normal mode");

   property p_tick_gap;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> !tick_o;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick longer than one cycle");

   property p_acc_restart;
      @(posedge clk_i) disable iff (rst_i)
      tick_o |=> state_reg.acc == ACC_W'($past(vsr_diff));
   endproperty
   a_acc_restart: assert property (p_acc_restart) else $error("integrator not restarted");

   property p_ans_pulse;
      @(posedge clk_i) disable iff (rst_i)
      !temp_query_i |=> !temp_answer_valid_o;
   endproperty
   a_ans_pulse: assert property (p_ans_pulse) else $error("answer without query");

   c_tick:  cover property (@(posedge clk_i) disable iff (rst_i) tick_o);
   c_chg:   cover property (@(posedge clk_i) disable iff (rst_i) charging_o ##1 discharging_o);
   c_query: cover property (@(posedge clk_i) disable iff (rst_i) temp_answer_valid_o);
   c_int:   cover property (@(posedge clk_i) disable iff (rst_i) tick_o && temp_source_select_i);

endmodule
`default_nettype wire

// File: verification/gda_cell_model.sv
// behavioural cell, sense resistor and thermistor feeding the sampler
`timescale 1ns/1ps
`default_nettype none
module gda_cell_model
   import gda_pkg::*;
(
   input  wire logic               clk_i,  // sample clock
   input  wire logic [5*ADC_W-1:0] set_i,  // cell, pos, neg, ext, int
   output logic [ADC_W-1:0]        cell_o, // cell voltage
   output logic [ADC_W-1:0]        pos_o,  // sense plus side
   output logic [ADC_W-1:0]        neg_o,  // sense minus side
   output logic [ADC_W-1:0]        ext_o,  // thermistor
   output logic [ADC_W-1:0]        int_o   // die sensor
);
   // levels settle one edge late, like a slow front end
   initial {cell_o, pos_o, neg_o, ext_o, int_o} = '0;
   always @(posedge clk_i)
      {cell_o, pos_o, neg_o, ext_o, int_o} <= set_i;
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the gauge acquisition block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gda_pkg::*;
   localparam int T = 8;
   logic clk_i = 0, rst_i = 1, normal_mode_i = 1;
   logic temp_source_select_i = 0, temp_query_i = 0;
   logic [ADC_W-1:0] cell_sense_input_i, thermistor_input_i, int_temp_i;
   logic [ADC_W-1:0] voltage_o, temperature_o, temp_answer_o, vr, tr, qa, p, n;
   logic signed [ADC_W-1:0] sense_pos_input_i, sense_neg_input_i;
   logic signed [31:0] remaining_charge_o, current_o, acc, rem, cur;
   logic signed [31:0] h [4];
   logic temp_answer_valid_o, charging_o, discharging_o, tick_o, tk, qv, chg, dis;
   logic [5*ADC_W-1:0] set = '0;
   int cnt, err_count = 0, checks = 0, seed = 1008, i;
   wire signed [31:0] d = 32'(sense_pos_input_i) - 32'(sense_neg_input_i);

   gda_cell_model u_cell (.clk_i, .set_i(set), .cell_o(cell_sense_input_i),
      .pos_o(sense_pos_input_i), .neg_o(sense_neg_input_i),
      .ext_o(thermistor_input_i), .int_o(int_temp_i));
   gda_acquisition #(.TICK_CYC(T)) DUT (.clk_i, .rst_i, .normal_mode_i,
      .cell_sense_input_i, .sense_pos_input_i, .sense_neg_input_i,
      .thermistor_input_i, .int_temp_i, .temp_source_select_i, .temp_query_i,
      .voltage_o, .remaining_charge_o, .current_o, .temperature_o, .temp_answer_o,
      .temp_answer_valid_o, .charging_o, .discharging_o, .tick_o);

   always #2 clk_i = ~clk_i;

   // average of the four history entries, summed wide to avoid wrap
   function automatic logic signed [31:0] exp_cur(input logic signed [31:0] a, b, c, e);
      return 32'((34'(a) + 34'(b) + 34'(c) + 34'(e)) >>> 2);
   endfunction

   function automatic logic [ADC_W-1:0] exp_temp(input logic sel,
                                                  input logic [ADC_W-1:0] ext, die);
      return (sel == TEMP_SRC_INT) ? die : ext;
   endfunction

   // cycle-accurate expectation of every output
   always @(posedge clk_i or posedge rst_i)
      if (rst_i)
      begin
         {cnt, tk, vr, tr, rem, cur, acc, qv, qa, chg, dis} <= '0;
         h <= '{default: '0};
      end
      else
      begin
         cnt <= (cnt == T-1) ? 0 : cnt + 1;
         tk <= normal_mode_i && cnt == T-1;
         qv <= temp_query_i;
         qa <= tr;
         chg <= d > 0;
         dis <= d < 0;
         acc <= tk ? d : acc + d;
         if (tk)
         begin
            vr <= cell_sense_input_i;
            tr <= exp_temp(temp_source_select_i, thermistor_input_i, int_temp_i);
            rem <= rem + acc;
            cur <= exp_cur(h[0], h[1], h[2], h[3]);
            h <= '{acc, h[0], h[1], h[2]};
         end
      end

   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   always @(negedge clk_i)
   begin
      cmp("tick", 32'(tk), 32'(tick_o));
      cmp("voltage", 32'(vr), 32'(voltage_o));
      cmp("charging", 32'(chg), 32'(charging_o));
      cmp("discharging", 32'(dis), 32'(discharging_o));
      cmp("charge", rem, remaining_charge_o);
      cmp("current", cur, current_o);
      cmp("temperature", 32'(tr), 32'(temperature_o));
      cmp("answer_valid", 32'(qv), 32'(temp_answer_valid_o));
      if (qv) cmp("answer", 32'(qa), 32'(temp_answer_o));
   end

   task close_out;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      for (i = 0; i < 240; i++)
      begin
         @(posedge clk_i);
         // zero sense around the idle stretch keeps the period sums unambiguous
         rst_i <= i inside {[170:172]};
         normal_mode_i <= !(i inside {[100:130]});
         temp_query_i <= 1'($random(seed));
         temp_source_select_i <= 1'($random(seed));
         p = 16'($random(seed) % 8000);
         n = (i % 7 == 0 || i inside {[80:145]}) ? p : 16'($random(seed) % 8000);
         if (i == 20)
            {p, n} = {16'h7FFF, 16'h8000};
         set <= {16'($random(seed)), p, n, 16'($random(seed)), 16'($random(seed))};
      end
      close_out();
   end

   initial
   begin
      #(4 * T * 100);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
